// ### core/pmw_consts.svh
// register offsets, field positions, reset values and timing counts of the power mode block
`ifndef PMW_CONSTS_SVH
`define PMW_CONSTS_SVH

// register byte addresses (word aligned)
`define PMW_ADDR_PSAVE    4'h0
`define PMW_ADDR_OSCPWR   4'h4
`define PMW_ADDR_DRV      4'h8
`define PMW_ADDR_STATUS   4'hC
`define PMW_ADDR_SRCSEL   4'h0
`define PMW_ADDR_PINWK    4'h0

// reset values
`define PMW_PSAVE_RST     8'h50
`define PMW_OSCPWR_RST    8'hA3
`define PMW_DRV_RST       8'h54
`define PMW_SRCSEL_RST    2'h0

// write keys in upper bits
`define PMW_PSAVE_KEY     4'h5
`define PMW_OSCPWR_KEY    3'h5
`define PMW_DRV_KEY       4'h5

// power save control bits
`define PMW_B_CORE_GATE   3
`define PMW_B_PERI_GATE   2
`define PMW_B_SRC_STOP    1
`define PMW_B_FAST_RC     0

// oscillator power control bits and the driver register regulator bit
`define PMW_B_SLOW_RC_PD  2
`define PMW_B_SUB_XTAL_PD 0
`define PMW_B_REG_OFF     0

// source clock encodings
`define PMW_SRC_FAST_RC   2'h0
`define PMW_SRC_EXT_XTAL  2'h1
`define PMW_SRC_SLOW_RC   2'h2
`define PMW_SRC_SUB_XTAL  2'h3

// wakeup waits in source clock cycles
`define PMW_IDLE_WAKE     15'h0002
`define PMW_SLEEP1_WAKE   15'h0008
`define PMW_SLEEP2_RC     15'h0080
`define PMW_SLEEP2_XTAL   15'h4000

`define PMW_PIN_WAKE_W    28

`endif

// ### core/pmw_pkg.sv
// types shared by the power mode and wakeup block
package pmw_pkg;

  typedef enum logic [5:0] {
    PMW_NORMAL = 6'h01,
    PMW_IDLE1  = 6'h02,
    PMW_IDLE2  = 6'h04,
    PMW_SLEEP1 = 6'h08,
    PMW_SLEEP2 = 6'h10,
    PMW_WAKING = 6'h20
  } pmw_state_t;

  typedef enum logic [1:0] {
    PMW_MODE_NORMAL = 2'h0,
    PMW_MODE_GREEN  = 2'h1,
    PMW_MODE_IDLE   = 2'h2,
    PMW_MODE_SLEEP  = 2'h3
  } pmw_mode_t;

endpackage : pmw_pkg

// ### core/pmw_power_ctl.sv
// power mode and wakeup controller with an avalon-mm register slave
//
// Behaviour
// RL1 - normal, green, two idle, two sleep modes
// RL2 - core gate bit enters first idle variant
// RL3 - peripheral gate bit enters second idle
// RL4 - idle wakeup completes in two source clocks
// RL5 - fast rc stop sleeps, eight cycle wake
// RL6 - source stop with fast rc waits 128
// RL7 - source stop with crystal waits 16k cycles
// RL8 - software selects slow rc, then regulator off
// RL9 - software starts sub crystal before selecting it
// RL10 - software restores regulator before fast source
// RL11 - regulator off only while in green mode
// RL12 - normal two calibrates fast rc from crystal
// RL13 - common wake sources wake idle and sleep
// RL14 - shared group peripherals wake first idle only
// RL15 - external lines never wake the device
// RL16 - pin toggle wake on 28 pins only
// RL17 - software keeps sub oscillator for timer wake
// RL18 - wakeup clears the causing gate bit
// RL19 - power save writes need upper key 0101
// RL20 - oscillator power writes need key 101
// RL21 - driver bit zero switches main regulator
//
// Decided for this implementation: the Avalon-MM register port and the register offsets.
`timescale 1ns/100ps
`include "pmw_consts.svh"

module pmw_power_ctl (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // avalon-mm slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // source clock in use and its tick
  input  wire logic [1:0]  source_select,
  input  wire logic        source_tick,
  // wake sources
  input  wire logic        external_reset_pin,
  input  wire logic [27:0] pin_wake_enable,
  input  wire logic [27:0] pin_toggle,
  input  wire logic        serial_periph_irq,
  input  wire logic        two_wire_irq,
  input  wire logic        converter_irq,
  input  wire logic        comparator_irq,
  input  wire logic        low_voltage_irq,
  input  wire logic        watch_timer_irq,
  input  wire logic        enhanced_timer_irq,
  input  wire logic        input_toggle_irq,
  input  wire logic [15:0] ext_line_wake_group,
  input  wire logic        converter_wake,
  input  wire logic        comparator_wake,
  input  wire logic        watch_timer_wake,
  // clock and power controls
  output logic             core_clk_en,
  output logic             periph_clk_en,
  output logic             source_osc_en,
  output logic             fast_rc_en,
  output logic             main_regulator,
  output logic             slow_rc_power_down,
  output logic             sub_crystal_power_down,
  output logic             calibrate_fast_rc,
  output logic [1:0]       power_mode
);

  // ==========================================================
  // registers
  logic [7:0]             psave_r, psave_nxt;
  logic [7:0]             oscpwr_r, oscpwr_nxt;
  logic [7:0]             drv_r, drv_nxt;
  pmw_pkg::pmw_state_t    state_r, state_nxt;
  logic [14:0]            wait_r, wait_nxt;
  logic [31:0]            rdata_r, rdata_nxt;
  logic                   rvalid_r, rvalid_nxt;
  logic                   wr_psave, wr_oscpwr, wr_drv;
  logic                   common_wake, shared_wake, wake_idle1, wake_other;
  logic                   green;

  // ==========================================================
  // bus handshake
  // writes never wait; a read waits one cycle so its registered data stand at the accept edge
  assign waitrequest = read && !rvalid_r;
  assign readdata    = rdata_r;

  // ==========================================================
  // wake source qualification
  always_comb begin
    // only the 28 toggle-capable pins exist here, so the port is that wide
    common_wake = external_reset_pin | (|(pin_wake_enable & pin_toggle)) |  // see RL16
                  low_voltage_irq | input_toggle_irq |
                  converter_wake | comparator_wake | watch_timer_wake;      // see RL13
    // shared group peripherals need the peripheral clock running
    shared_wake = serial_periph_irq | two_wire_irq |
                  comparator_irq | enhanced_timer_irq;                      // see RL14
    // ext lines, converter and watch timer irqs never wake; left unread on purpose
    wake_idle1  = common_wake | shared_wake;                                // see RL15
    wake_other  = common_wake;                                              // see RL14
  end

  // ==========================================================
  // register writes with key check
  always_comb begin
    wr_psave  = write && (address == `PMW_ADDR_PSAVE) &&
                (writedata[7:4] == `PMW_PSAVE_KEY);                         // see RL19
    wr_oscpwr = write && (address == `PMW_ADDR_OSCPWR) &&
                (writedata[7:5] == `PMW_OSCPWR_KEY);                        // see RL20
    wr_drv    = write && (address == `PMW_ADDR_DRV) &&
                (writedata[7:4] == `PMW_DRV_KEY);
  end

  // ==========================================================
  // mode sequencer
  always_comb begin
    psave_nxt  = psave_r;
    state_nxt  = state_r;
    wait_nxt   = wait_r;
    case (state_r)
      pmw_pkg::PMW_NORMAL: begin
        if (wr_psave) begin
          psave_nxt = {`PMW_PSAVE_KEY, writedata[3:0]};
          // priority: deepest requested stop wins
          if (writedata[`PMW_B_SRC_STOP]) begin
            state_nxt = pmw_pkg::PMW_SLEEP2;                                // see RL6
          end else if (writedata[`PMW_B_FAST_RC] &&
                       source_select == `PMW_SRC_FAST_RC) begin
            state_nxt = pmw_pkg::PMW_SLEEP1;                                // see RL5
          end else if (writedata[`PMW_B_PERI_GATE]) begin
            state_nxt = pmw_pkg::PMW_IDLE2;                                 // see RL3
          end else if (writedata[`PMW_B_CORE_GATE]) begin
            state_nxt = pmw_pkg::PMW_IDLE1;                                 // see RL2
          end else begin
            // fast rc stop is invalid on other sources and is dropped when no gate bit is set with it
            psave_nxt[`PMW_B_FAST_RC] = 1'b0;                               // see RL5
          end
        end
      end
      pmw_pkg::PMW_IDLE1: begin
        if (wake_idle1) begin
          state_nxt = pmw_pkg::PMW_WAKING;
          wait_nxt  = `PMW_IDLE_WAKE;                                       // see RL4
        end
      end
      pmw_pkg::PMW_IDLE2: begin
        if (wake_other) begin
          state_nxt = pmw_pkg::PMW_WAKING;
          wait_nxt  = `PMW_IDLE_WAKE;                                       // see RL4
        end
      end
      pmw_pkg::PMW_SLEEP1: begin
        if (wake_other) begin
          state_nxt = pmw_pkg::PMW_WAKING;
          wait_nxt  = `PMW_SLEEP1_WAKE;                                     // see RL5
        end
      end
      pmw_pkg::PMW_SLEEP2: begin
        if (wake_other) begin
          state_nxt = pmw_pkg::PMW_WAKING;
          if (source_select == `PMW_SRC_FAST_RC) begin
            wait_nxt = `PMW_SLEEP2_RC;                                      // see RL6
          end else begin
            wait_nxt = `PMW_SLEEP2_XTAL;                                    // see RL7
          end
        end
      end
      pmw_pkg::PMW_WAKING: begin
        if (source_tick) begin
          if (wait_r <= 15'h0001) begin
            wait_nxt  = 15'h0000;
            state_nxt = pmw_pkg::PMW_NORMAL;
            psave_nxt = `PMW_PSAVE_RST;                                     // see RL18
          end else begin
            wait_nxt = wait_r - 15'h0001;
          end
        end
      end
      default: begin
        state_nxt = pmw_pkg::PMW_NORMAL;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      psave_r <= `PMW_PSAVE_RST;
      state_r <= pmw_pkg::PMW_NORMAL;
      wait_r  <= 15'h0000;
    end else begin
      psave_r <= psave_nxt;
      state_r <= state_nxt;
      wait_r  <= wait_nxt;
    end
  end

  // ==========================================================
  // oscillator power and driver registers
  // keyed writes land in any state, so software can restore the regulator while green
  always_comb begin
    oscpwr_nxt = oscpwr_r;
    drv_nxt    = drv_r;
    if (wr_oscpwr) begin
      oscpwr_nxt = {`PMW_OSCPWR_KEY, writedata[4:0]};                       // see RL20
    end
    if (wr_drv) begin
      drv_nxt = {`PMW_DRV_KEY, writedata[3:0]};                             // see RL21
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      oscpwr_r <= `PMW_OSCPWR_RST;
      drv_r    <= `PMW_DRV_RST;
    end else begin
      oscpwr_r <= oscpwr_nxt;
      drv_r    <= drv_nxt;
    end
  end

  // ==========================================================
  // read mux
  // data are captured in the wait cycle and held, so they do not move at the accept edge
  always_comb begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = 1'b0;
    if (read && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rdata_nxt  = 32'h0000_0000;
      if (address == `PMW_ADDR_PSAVE) begin
        rdata_nxt = {24'h00_0000, psave_r};
      end else if (address == `PMW_ADDR_OSCPWR) begin
        rdata_nxt = {24'h00_0000, oscpwr_r};
      end else if (address == `PMW_ADDR_DRV) begin
        rdata_nxt = {24'h00_0000, drv_r};
      end else if (address == `PMW_ADDR_STATUS) begin
        rdata_nxt = {24'h00_0000, 2'h0, state_r};
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_r  <= 32'h0000_0000;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // ==========================================================
  // clock, oscillator and regulator outputs
  always_comb begin
    // green: running with a 32 kHz source, the only place the regulator may drop
    green = (state_r == pmw_pkg::PMW_NORMAL) &&
            (source_select == `PMW_SRC_SLOW_RC ||
             source_select == `PMW_SRC_SUB_XTAL);                           // see RL1
    core_clk_en   = (state_r == pmw_pkg::PMW_NORMAL);                       // see RL2
    periph_clk_en = (state_r == pmw_pkg::PMW_NORMAL) ||
                    (state_r == pmw_pkg::PMW_IDLE1);                        // see RL3
    source_osc_en = (state_r != pmw_pkg::PMW_SLEEP2);                       // see RL6
    fast_rc_en    = (state_r != pmw_pkg::PMW_SLEEP1) &&
                    (state_r != pmw_pkg::PMW_SLEEP2);                       // see RL5
    // an off request outside green is ignored to keep the core supplied
    main_regulator = !(drv_r[`PMW_B_REG_OFF] && green);                     // see RL11
    slow_rc_power_down     = oscpwr_r[`PMW_B_SLOW_RC_PD];
    sub_crystal_power_down = oscpwr_r[`PMW_B_SUB_XTAL_PD];                  // see RL17
    calibrate_fast_rc = (state_r == pmw_pkg::PMW_NORMAL) &&
                        (source_select == `PMW_SRC_FAST_RC) &&
                        !oscpwr_r[`PMW_B_SUB_XTAL_PD];                      // see RL12
    if (green) begin
      power_mode = pmw_pkg::PMW_MODE_GREEN;
    end else if (state_r == pmw_pkg::PMW_IDLE1 || state_r == pmw_pkg::PMW_IDLE2) begin
      power_mode = pmw_pkg::PMW_MODE_IDLE;
    end else if (state_r == pmw_pkg::PMW_SLEEP1 || state_r == pmw_pkg::PMW_SLEEP2) begin
      power_mode = pmw_pkg::PMW_MODE_SLEEP;
    end else begin
      power_mode = pmw_pkg::PMW_MODE_NORMAL;
    end
  end

endmodule : pmw_power_ctl

// ### testbench/pmw_power_ctl_props.sv
// port assertions for the power mode controller
`timescale 1ns/100ps
module pmw_power_ctl_props (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // register bus
  input wire logic [3:0]  address,
  input wire logic        write,
  input wire logic [31:0] writedata,
  // controls
  input wire logic [1:0]  source_select,
  input wire logic        core_clk_en,
  input wire logic        periph_clk_en,
  input wire logic        source_osc_en,
  input wire logic        fast_rc_en,
  input wire logic        main_regulator,
  input wire logic        slow_rc_power_down,
  input wire logic        sub_crystal_power_down,
  input wire logic        calibrate_fast_rc,
  input wire logic [1:0]  power_mode
);
  // ==========
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  idle_entry_a: assert property (write && address == 4'h0 && writedata[7:0] == 8'h58 && core_clk_en
    |=> !core_clk_en && periph_clk_en && power_mode == 2'h2) else $error("no idle entry");
  idle2_entry_a: assert property (write && address == 4'h0 && writedata[7:0] == 8'h54 && core_clk_en
    |=> !periph_clk_en && source_osc_en) else $error("no second idle entry");
  key_refuse_a: assert property (write && address == 4'h0 && writedata[7:4] != 4'h5 && core_clk_en
    |=> core_clk_en) else $error("keyless write taken");
  reg_green_a: assert property (!main_regulator |-> power_mode == 2'h1)
    else $error("regulator off outside green");
  reg_on_a: assert property (write && address == 4'h8 && writedata[7:4] == 4'h5 && !writedata[0]
    |=> main_regulator) else $error("regulator not on");
  osc_write_a: assert property (write && address == 4'h4 && writedata[7:5] == 3'h5
    |=> slow_rc_power_down == $past(writedata[2]) && sub_crystal_power_down == $past(writedata[0]))
    else $error("osc power write lost");
  sleep_rc_a: assert property (power_mode == 2'h3 |-> !fast_rc_en && !core_clk_en)
    else $error("sleep with fast rc running");
  src_stop_a: assert property (!source_osc_en |-> power_mode == 2'h3)
    else $error("source stopped outside sleep");
  calib_a: assert property (calibrate_fast_rc |-> core_clk_en && source_select == 2'h0
    && !sub_crystal_power_down) else $error("calibration out of place");
endmodule : pmw_power_ctl_props

bind pmw_power_ctl pmw_power_ctl_props i_pmw_power_ctl_props (.clk, .reset, .address, .write,
  .writedata, .source_select, .core_clk_en, .periph_clk_en, .source_osc_en, .fast_rc_en,
  .main_regulator, .slow_rc_power_down, .sub_crystal_power_down, .calibrate_fast_rc, .power_mode);

// ### testbench/tb.sv
// self-checking bench for the power mode controller
`timescale 1ns/100ps
`include "pmw_consts.svh"
module tb;
  // ==========
  // stimulus and design
  logic        clk = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0, source_tick = 1'b0;
  logic [3:0]  address = 4'h0;
  logic [7:0]  wd = 8'h00;
  logic [1:0]  source_select = 2'h0, power_mode;
  logic [13:0] wk = 14'h0000;
  logic [31:0] readdata, q;
  logic        waitrequest, core_clk_en, periph_clk_en, source_osc_en, fast_rc_en;
  logic        main_regulator, slow_rc_power_down, sub_crystal_power_down, calibrate_fast_rc;
  int          failures = 0, comparisons = 0;
  always #12.5 clk = ~clk;
  // wk packs every wake input so one loop walks them all
  pmw_power_ctl i_pmw_power_ctl (.clk, .reset, .address, .read, .write,
    .writedata({24'h000000, wd}), .readdata, .waitrequest, .source_select, .source_tick,
    .external_reset_pin(wk[9]), .pin_wake_enable(28'h8000000), .pin_toggle({wk[13], 27'h0}),
    .serial_periph_irq(wk[0]), .two_wire_irq(wk[1]), .comparator_irq(wk[2]),
    .enhanced_timer_irq(wk[3]), .low_voltage_irq(wk[4]), .input_toggle_irq(wk[5]),
    .converter_wake(wk[6]), .comparator_wake(wk[7]), .watch_timer_wake(wk[8]),
    .converter_irq(wk[10]), .watch_timer_irq(wk[11]), .ext_line_wake_group({16{wk[12]}}),
    .core_clk_en, .periph_clk_en, .source_osc_en, .fast_rc_en, .main_regulator,
    .slow_rc_power_down, .sub_crystal_power_down, .calibrate_fast_rc, .power_mode);
  task automatic summarize;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [31:0] r);
    int n = 0;
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= a;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      failures++;
      summarize();
    end
    r = readdata;
    read <= 1'b0;
    write <= 1'b0;
    #1;
  endtask : bus
  task automatic tick(input int m);
    repeat (m) begin
      @(posedge clk);
      source_tick <= 1'b1;
      @(posedge clk);
      source_tick <= 1'b0;
    end
    #1;
  endtask : tick
  task automatic t_reset;
    logic [3:0] a [5] = '{`PMW_ADDR_PSAVE, `PMW_ADDR_OSCPWR, `PMW_ADDR_DRV, `PMW_ADDR_STATUS, 4'h1};
    logic [7:0] e [5] = '{8'h50, 8'hA3, 8'h54, 8'h01, 8'h00};
    chk({main_regulator, sub_crystal_power_down, slow_rc_power_down}, 32'h6);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, a[i], 8'h00, q);
      chk(q, {24'h000000, e[i]});
    end
  endtask : t_reset
  task automatic t_controls;
    bus(1'b1, `PMW_ADDR_PSAVE, 8'h68, q);
    chk(core_clk_en, 32'h1);
    @(posedge clk);
    source_select <= `PMW_SRC_EXT_XTAL;
    bus(1'b1, `PMW_ADDR_PSAVE, 8'h51, q);
    chk(core_clk_en, 32'h1);
    @(posedge clk);
    source_select <= `PMW_SRC_SLOW_RC;
    bus(1'b1, `PMW_ADDR_DRV, 8'h55, q);
    chk({power_mode, main_regulator}, 32'h2);
    bus(1'b1, `PMW_ADDR_DRV, 8'h54, q);
    chk({power_mode, main_regulator}, 32'h3);
    @(posedge clk);
    source_select <= `PMW_SRC_FAST_RC;
    #1 chk({power_mode, main_regulator}, 32'h1);
    bus(1'b1, `PMW_ADDR_OSCPWR, 8'hA4, q);
    chk({slow_rc_power_down, sub_crystal_power_down, calibrate_fast_rc}, 32'h5);
    bus(1'b1, `PMW_ADDR_OSCPWR, 8'h63, q);
    chk(sub_crystal_power_down, 32'h0);
  endtask : t_controls
  // a source that must not wake is followed by one that must, so each round ends awake
  task automatic nap(input logic [7:0] d, input int n, input int i, input logic ok);
    int k = 0;
    bus(1'b1, `PMW_ADDR_PSAVE, d, q);
    chk({core_clk_en, periph_clk_en, power_mode}, d[3] ? 32'h6 : d[2] ? 32'h2 : 32'h3);
    @(posedge clk);
    wk[i] <= 1'b1;
    @(posedge clk);
    wk[i] <= 1'b0;
    if (!ok) begin
      tick(4);
      chk(core_clk_en, 32'h0);
      @(posedge clk);
      wk[4] <= 1'b1;
      @(posedge clk);
      wk[4] <= 1'b0;
    end
    tick(n - 1);
    chk(core_clk_en, 32'h0);
    tick(1);
    while (core_clk_en !== 1'b1 && k < 3) begin
      @(posedge clk);
      #1 k++;
    end
    chk(core_clk_en, 32'h1);
    bus(1'b0, `PMW_ADDR_PSAVE, 8'h00, q);
    chk(q, 32'h50);
  endtask : nap
  task automatic t_wake;
    logic [7:0]  d [5] = '{8'h58, 8'h54, 8'h51, 8'h52, 8'h52};
    int          n [5] = '{2, 2, 8, 128, 16384};
    logic [13:0] m [5] = '{14'h23FF, 14'h23F0, 14'h23F0, 14'h23F0, 14'h23F0};
    for (int j = 0; j < 5; j++) begin
      @(posedge clk);
      source_select <= (j == 4) ? `PMW_SRC_EXT_XTAL : `PMW_SRC_FAST_RC;
      for (int i = 0; i < 14; i++) begin
        if (j < 4 || i == 4) nap(d[j], n[j], i, m[j][i]);
      end
    end
  endtask : t_wake
  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_controls();
    t_wake();
    summarize();
  end
endmodule : tb
